//--- pkg/acs_consts.vh
`ifndef ACS_CONSTS_VH
`define ACS_CONSTS_VH
`define ACS_IDX_OFS_REF   8'h65
`define ACS_IDX_AVG       8'h68
`define ACS_IDX_STATUS    8'h6A
`define ACS_IDX_PIN       8'h6B
`define ACS_IDX_CTRL      8'h70
`define ACS_RST_OFS_REF   8'h01
`define ACS_RST_AVG       8'h61
`define ACS_RST_PIN       8'h00
`define ACS_RST_CTRL      8'h02
`define ACS_RST_OFS_AVG   3'h6
`define ACS_RST_LIN_AVG   3'h1
`define ACS_OFS_AVG_HI    6
`define ACS_OFS_AVG_LO    4
`define ACS_LIN_AVG_HI    2
`define ACS_LIN_AVG_LO    0
`define ACS_STAT_SEL_HI   2
`define ACS_STAT_SEL_LO   1
`define ACS_BIT_OFFSET_REFERENCE_SELECT     2
`define ACS_BIT_TRIG_SRC  0
`define ACS_BIT_BG_EN     0
`define ACS_BIT_FG_EN     1
`define ACS_BIT_SOFT_TRIG 2
`define ACS_BIT_STOPPED   1
`define ACS_BIT_FOREGROUND_FINISHED_FLAG   0
`endif

//--- rtl/acs_top.v
`timescale 1ns/10ps
`include "acs_consts.vh"
module acs_top (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        calib_trigger_pin,
  input  wire        fg_finished,
  input  wire        bg_halted,
  input  wire        calib_running,
  input  wire [2:0]  calib_state_code,
  input  wire        alarm_in,
  output reg         offset_reference_select,
  output reg  [2:0]  offset_averaging_depth,
  output reg  [2:0]  linearity_averaging_depth,
  output reg         background_calib_enable,
  output reg         foreground_calib_enable,
  output reg         calib_trigger,
  output reg         calib_status_pin
);
  localparam [9:0] IDX_OFS   = {2'b00, `ACS_IDX_OFS_REF};
  localparam [9:0] IDX_AVG   = {2'b00, `ACS_IDX_AVG};
  localparam [9:0] IDX_STA   = {2'b00, `ACS_IDX_STATUS};
  localparam [9:0] IDX_PIN   = {2'b00, `ACS_IDX_PIN};
  localparam [9:0] IDX_CTL   = {2'b00, `ACS_IDX_CTRL};

  localparam [1:0] SEL_DONE  = 2'b00;
  localparam [1:0] SEL_STOP  = 2'b01;
  localparam [1:0] SEL_ALARM = 2'b10;

  reg  [7:0] ofs_ref_r;
  reg  [7:0] avg_r;
  reg  [7:0] pin_r;
  reg  [7:0] ctrl_r;
  reg        foreground_finished_flag_r;
  reg        stopped_r;
  reg        stopped_nxt;
  reg  [2:0] code_r;
  reg  [2:0] code_hold_r;
  reg  [7:0] sync1_r;
  reg  [7:0] sync2_r;
  reg  [7:0] rd_nxt;
  reg        trigger_nxt;
  reg        status_pin_nxt;

  // Engine-side inputs in one vector so the synchroniser is one loop
  wire [7:0] async_in = {calib_state_code, alarm_in, calib_running,
                         bg_halted, fg_finished, calib_trigger_pin};

  wire [9:0] word_idx = paddr[11:2];
  // First access cycle only; pready is registered, so this lasts one cycle
  wire       acc      = psel && penable && !pready;
  // Completing edge: a write lands where the master samples pready high
  wire       done     = psel && penable && pready;
  wire       wr       = done && pwrite && pstrb[0];

  wire       hit_ofs  = word_idx == IDX_OFS;
  wire       hit_avg  = word_idx == IDX_AVG;
  wire       hit_sta  = word_idx == IDX_STA;
  wire       hit_pin  = word_idx == IDX_PIN;
  wire       hit_ctl  = word_idx == IDX_CTL;
  wire       mapped   = hit_ofs | hit_avg | hit_sta | hit_pin | hit_ctl;

  wire       trig_pin_s = sync2_r[0];
  wire       fg_fin_s   = sync2_r[1];
  wire       bg_halt_s  = sync2_r[2];
  wire       run_s      = sync2_r[3];
  wire       alarm_s    = sync2_r[4];
  wire [2:0] code_s     = sync2_r[7:5];

  // Fields of the stored registers
  wire       offset_reference_select_f     = ofs_ref_r[`ACS_BIT_OFFSET_REFERENCE_SELECT];
  wire [2:0] ofs_avg_f   = avg_r[`ACS_OFS_AVG_HI:`ACS_OFS_AVG_LO];
  wire [2:0] lin_avg_f   = avg_r[`ACS_LIN_AVG_HI:`ACS_LIN_AVG_LO];
  wire       bg_en_f     = ctrl_r[`ACS_BIT_BG_EN];
  wire       fg_en_f     = ctrl_r[`ACS_BIT_FG_EN];
  wire       soft_trig_f = ctrl_r[`ACS_BIT_SOFT_TRIG];
  wire       trig_src_f  = pin_r[`ACS_BIT_TRIG_SRC];
  wire [1:0] stat_sel_f  = pin_r[`ACS_STAT_SEL_HI:`ACS_STAT_SEL_LO];

  // Two flops per engine input; only the second stage is read by logic
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_sync
      always @(posedge clk) begin
        if (sys_rst) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= async_in[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  always @* begin
    rd_nxt = 8'h00;
    case (word_idx)
      IDX_OFS: begin
        rd_nxt = ofs_ref_r;
      end
      IDX_AVG: begin
        rd_nxt = avg_r;
      end
      IDX_STA: begin
        rd_nxt = {3'b000, code_r, stopped_r, foreground_finished_flag_r};
      end
      IDX_PIN: begin
        rd_nxt = pin_r;
      end
      IDX_CTL: begin
        rd_nxt = ctrl_r;
      end
      default: begin
        rd_nxt = 8'h00;
      end
    endcase
  end

  // One wait state: pready rises in the second access cycle
  always @(posedge clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
    end else begin
      pready <= acc;
    end
  end

  // Unmapped offsets answer with an error in the same cycle as pready
  always @(posedge clk) begin
    if (sys_rst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= acc && !mapped;
    end
  end

  // Read data stands only while pready does, zero otherwise
  always @(posedge clk) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
    end else if (acc && !pwrite) begin
      prdata <= {24'h000000, rd_nxt};
    end else begin
      prdata <= 32'h00000000;
    end
  end

  // Stored values only; reserved bits keep what software wrote
  always @(posedge clk) begin
    if (sys_rst) begin
      ofs_ref_r <= `ACS_RST_OFS_REF;
    end else if (wr && hit_ofs) begin
      ofs_ref_r <= pwdata[7:0];
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      avg_r <= `ACS_RST_AVG;
    end else if (wr && hit_avg) begin
      avg_r <= pwdata[7:0];
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      pin_r <= `ACS_RST_PIN;
    end else if (wr && hit_pin) begin
      pin_r <= pwdata[7:0];
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      ctrl_r <= `ACS_RST_CTRL;
    end else if (wr && hit_ctl) begin
      ctrl_r <= pwdata[7:0];
    end
  end

  // Status register has no write path; wr never reaches it

  // Flags mirror engine levels, so no set/clear race arises
  always @(posedge clk) begin
    if (sys_rst) begin
      foreground_finished_flag_r <= 1'b0;
    end else begin
      foreground_finished_flag_r <= fg_fin_s;
    end
  end

  // The code is three bits from another domain; it is taken only after
  // two equal samples, so a half-changed code never reaches software
  always @(posedge clk) begin
    if (sys_rst) begin
      code_hold_r <= 3'b000;
    end else begin
      code_hold_r <= code_s;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      code_r <= 3'b000;
    end else if (code_s == code_hold_r) begin
      code_r <= code_s;
    end
  end

  // With background off the flag follows foreground completion
  always @* begin
    stopped_nxt = fg_fin_s;
    if (bg_en_f && run_s) begin
      stopped_nxt = 1'b0;
    end else if (bg_en_f) begin
      stopped_nxt = bg_halt_s;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      stopped_r <= 1'b0;
    end else begin
      stopped_r <= stopped_nxt;
    end
  end

  always @* begin
    if (trig_src_f) begin
      trigger_nxt = trig_pin_s;
    end else begin
      trigger_nxt = soft_trig_f;
    end
  end

  always @* begin
    case (stat_sel_f)
      SEL_DONE: begin
        status_pin_nxt = foreground_finished_flag_r;
      end
      SEL_STOP: begin
        status_pin_nxt = stopped_r;
      end
      SEL_ALARM: begin
        status_pin_nxt = alarm_s;
      end
      default: begin
        status_pin_nxt = 1'b0;
      end
    endcase
  end

  // 0 targets mid-code, 1 follows the spare converter
  always @(posedge clk) begin
    if (sys_rst) begin
      offset_reference_select <= 1'b0;
    end else begin
      offset_reference_select <= offset_reference_select_f;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      offset_averaging_depth <= `ACS_RST_OFS_AVG;
    end else begin
      offset_averaging_depth <= ofs_avg_f;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      linearity_averaging_depth <= `ACS_RST_LIN_AVG;
    end else begin
      linearity_averaging_depth <= lin_avg_f;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      background_calib_enable <= 1'b0;
    end else begin
      background_calib_enable <= bg_en_f;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      foreground_calib_enable <= 1'b1;
    end else begin
      foreground_calib_enable <= fg_en_f;
    end
  end

  // Trigger passes one register, so the pin path sees three flops
  always @(posedge clk) begin
    if (sys_rst) begin
      calib_trigger <= 1'b0;
    end else begin
      calib_trigger <= trigger_nxt;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      calib_status_pin <= 1'b0;
    end else begin
      calib_status_pin <= status_pin_nxt;
    end
  end
endmodule

//--- tb/acs_checker.sv
`timescale 1ns/10ps
module acs_checker (
  input wire        clk,
  input wire        sys_rst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        offset_reference_select,
  input wire [2:0]  offset_averaging_depth,
  input wire [2:0]  linearity_averaging_depth,
  input wire        background_calib_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Bench always writes full strobes, so strobe is left out here
  wire wd = psel && penable && pready && pwrite;
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("late ready");
  property p_pls; pready |=> !pready; endproperty
  a_pls: assert property (p_pls) else $error("ready too long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("lone error");
  property p_rd0; !pready |-> prdata == 0; endproperty
  a_rd0: assert property (p_rd0) else $error("stray data");
  property p_ro; pready && !pwrite && paddr == 12'h1A8 |-> !prdata[31:5];
  endproperty
  a_ro: assert property (p_ro) else $error("status top bits");
  property p_ref; wd && paddr == 12'h194
    |=> ##1 offset_reference_select == $past(pwdata[2], 2); endproperty
  a_ref: assert property (p_ref) else $error("ref select");
  property p_avg; wd && paddr == 12'h1A0 |=> ##1 {offset_averaging_depth,
    linearity_averaging_depth} == $past({pwdata[6:4], pwdata[2:0]}, 2);
  endproperty
  a_avg: assert property (p_avg) else $error("avg depth");
  property p_bg; wd && paddr == 12'h1C0
    |=> ##1 background_calib_enable == $past(pwdata[0], 2); endproperty
  a_bg: assert property (p_bg) else $error("bg enable");
  c_err: cover property (pslverr);
  c_wr: cover property (wd);
  c_rd: cover property (pready && !pwrite);
endmodule
bind acs_top acs_checker acs_checker_inst (.*);

//--- tb/tb_acs_top.sv
`timescale 1ns/10ps
module tb_acs_top;
  logic        clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdv;
  logic [3:0]  pstrb = 4'hF;
  logic        calib_trigger_pin = 0, fg_finished = 0, bg_halted = 0;
  logic        calib_running = 0, alarm_in = 0, pready, pslverr, ev;
  logic [2:0]  calib_state_code = 0, offset_averaging_depth;
  logic [2:0]  linearity_averaging_depth;
  logic        offset_reference_select, background_calib_enable;
  logic        foreground_calib_enable, calib_trigger, calib_status_pin;
  int          num_errors = 0, tests_run = 0, cyc = 0;
  acs_top acs_top_inst (.*);
  initial forever #10 clk = ~clk;
  task conclude;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      conclude;
    end
  end
  task cmp(input string n, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk) penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    {rdv, ev} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    repeat (2) @(posedge clk);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    acc(0, a, 0);
    cmp($sformatf("reg %h", a), e, rdv);
  endtask
  // Covers the two sync flops plus flag and output registers
  task w6;
    repeat (6) @(posedge clk);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 0;
    @(posedge clk);
    rd(12'h194, 1);
    rd(12'h1A0, 8'h61);
    rd(12'h1AC, 0);
    rd(12'h1C0, 2);
    rd(12'h1A8, 0);
    $display("reset test done");
    acc(1, 12'h1C0, 1);
    acc(1, 12'h194, 5);
    rd(12'h194, 5);
    cmp("offset_reference_select", 1, offset_reference_select);
    acc(1, 12'h194, 1);
    cmp("offset_reference_select", 0, offset_reference_select);
    acc(1, 12'h1A0, 8'h17);
    rd(12'h1A0, 8'h17);
    cmp("offset_averaging_depth", 1, offset_averaging_depth);
    cmp("linearity_averaging_depth", 7, linearity_averaging_depth);
    $display("settings test done");
    acc(1, 12'h1C0, 2);
    {fg_finished, calib_state_code} <= 4'hD;
    w6;
    rd(12'h1A8, 8'h17);
    acc(1, 12'h1A8, 0);
    rd(12'h1A8, 8'h17);
    acc(1, 12'h1C0, 3);
    bg_halted <= 1;
    w6;
    rd(12'h1A8, 8'h17);
    calib_running <= 1;
    w6;
    rd(12'h1A8, 8'h15);
    $display("status test done");
    acc(1, 12'h1C0, 7);
    cmp("calib_trigger", 1, calib_trigger);
    acc(1, 12'h1AC, 1);
    cmp("calib_trigger", 0, calib_trigger);
    calib_trigger_pin <= 1;
    alarm_in <= 1;
    w6;
    cmp("calib_trigger", 1, calib_trigger);
    for (int i = 0; i < 4; i++) begin
      acc(1, 12'h1AC, i * 2);
      cmp("calib_status_pin", i % 2 == 0, calib_status_pin);
    end
    $display("pins test done");
    acc(0, 12'h004, 0);
    cmp("pslverr", 1, ev);
    cmp("prdata", 0, rdv);
    $display("error test done");
    conclude;
  end
endmodule
